// [flash_crc_scan_params.svh]
`ifndef FLASH_CRC_SCAN_PARAMS_SVH
`define FLASH_CRC_SCAN_PARAMS_SVH

// register addresses in the sfr space
`define CTRL_ADDR 20'hf02f0
`define RESULT_ADDR 20'hf02f2

// control register layout
`define CTRL_EN_BIT 7
`define CTRL_ZERO_BIT 6
`define CTRL_RANGE_LSB 0
`define CTRL_RANGE_MSB 5
`define CTRL_WMASK 8'hbf
`define CTRL_RESET 8'h00
`define RANGE_MAX 6'h0f

// result register
`define RESULT_RESET 16'h0000

// ccitt generator, x^16 + x^12 + x^5 + 1 without the x^16 term
`define CRC_POLY 16'h1021

// words per 16 KB unit is 4096, so the last word is that count times units minus two
`define LAST_WORD_OFFSET 17'h00ffe
`define UNIT_SHIFT 12

`endif

// [flash_crc_scan_pkg.sv]
package flash_crc_scan_pkg;

  typedef enum logic [1:0] {
    ACC_BIT = 2'h0,
    ACC_BYTE = 2'h1,
    ACC_WORD = 2'h2
  } acc_e;

  // gray along idle -> fetch -> drain -> done -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_DRAIN = 2'h3,
    ST_DONE = 2'h2
  } scan_state_e;

  typedef struct packed {
    logic [19:0] addr;
    logic wr;
    logic rd;
    acc_e acc;
    logic [15:0] wdata;
    logic [2:0] bit_pos;
    logic bit_val;
  } sfr_req_s;

endpackage

// [crc16_word.sv]
`timescale 1ns/1ps
`include "flash_crc_scan_params.svh"

module crc16_word (
  input wire logic [15:0] crc_in,
  input wire logic [31:0] data,
  output logic [15:0] crc_out
);

  logic [15:0] chain [0:32];

  assign chain[0] = crc_in;

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_bit
      logic fb;
      // bit 31 enters first
      assign fb = chain[i][15] ^ data[31 - i];
      assign chain[i + 1] = {chain[i][14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
  endgenerate

  assign crc_out = chain[32];

endmodule

// [flash_crc_scan.sv]
`timescale 1ns/1ps
`include "flash_crc_scan_params.svh"

module flash_crc_scan (
  input wire logic clock,
  input wire logic resetn,
  input wire flash_crc_scan_pkg::sfr_req_s sfr_req,
  output logic [15:0] sfr_rdata,
  input wire logic halt_exec,
  output logic halt_release,
  output logic scan_busy,
  output logic flash_rd,
  output logic [17:0] flash_addr,
  input wire logic [31:0] flash_rdata,
  output logic [7:0] flash_check_control,
  output logic [15:0] flash_check_result
);

  function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] pos,
                                         input logic val);
    logic [7:0] r;
    r = v;
    r[pos] = val;
    return r;
  endfunction

  logic rst_meta_q;
  logic rst_n_q;
  flash_crc_scan_pkg::scan_state_e state_q;
  flash_crc_scan_pkg::scan_state_e state_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [15:0] res_q;
  logic [15:0] res_d;
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic rd_q;
  logic rd_d;
  logic data_valid_q;
  logic release_q;
  logic busy_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // synchroniser for reset release
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // register decode
  logic hit_ctrl;
  logic hit_res;
  logic ctrl_byte_wr;
  logic ctrl_bit_wr;
  logic res_wr;
  logic enable;
  logic [5:0] range_sel;
  logic range_ok;
  logic [16:0] last_word_wide;
  logic [15:0] last_word;
  logic scanning;
  logic start;
  logic [7:0] ctrl_wval;
  logic [15:0] crc_next;

  assign hit_ctrl = sfr_req.addr == `CTRL_ADDR;
  assign hit_res = sfr_req.addr == `RESULT_ADDR;
  assign ctrl_byte_wr = sfr_req.wr && hit_ctrl && sfr_req.acc == flash_crc_scan_pkg::ACC_BYTE;
  assign ctrl_bit_wr = sfr_req.wr && hit_ctrl && sfr_req.acc == flash_crc_scan_pkg::ACC_BIT;
  assign enable = ctrl_q[`CTRL_EN_BIT];
  assign range_sel = ctrl_q[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB];
  assign scanning = state_q == flash_crc_scan_pkg::ST_FETCH
                 || state_q == flash_crc_scan_pkg::ST_DRAIN;
  // engine owns the result while scanning, so software writes made during a scan are dropped
  assign res_wr = sfr_req.wr && hit_res && sfr_req.acc == flash_crc_scan_pkg::ACC_WORD
               && enable && !scanning;

  // bit 6 is forced low on every write path
  assign ctrl_wval = (ctrl_byte_wr ? sfr_req.wdata[7:0]
                   : put_bit(ctrl_q, sfr_req.bit_pos, sfr_req.bit_val)) & `CTRL_WMASK;
  assign ctrl_d = (ctrl_byte_wr || ctrl_bit_wr) ? ctrl_wval : ctrl_q;

  // prohibited range codes never start a scan
  assign range_ok = range_sel <= `RANGE_MAX;
  // (n+1)*4096 words less the excluded last word, index of the final one
  assign last_word_wide = {1'b0, range_sel[3:0], 12'h000} + `LAST_WORD_OFFSET;
  assign last_word = last_word_wide[15:0];

  // a scan can only begin from the halt instruction itself
  assign start = state_q == flash_crc_scan_pkg::ST_IDLE && halt_exec && enable;

  crc16_word i_crc16_word (
    .crc_in(res_q),
    .data(flash_rdata),
    .crc_out(crc_next)
  );

  always_comb
  begin
    state_d = state_q;
    word_d = word_q;
    rd_d = 1'b0;
    unique case (state_q)
      flash_crc_scan_pkg::ST_IDLE:
      begin
        if (start)
        begin
          if (range_ok)
          begin
            state_d = flash_crc_scan_pkg::ST_FETCH;
            word_d = 16'h0000;
            rd_d = 1'b1;
          end
          else
          begin
            // let the cpu go rather than hang with interrupts masked
            state_d = flash_crc_scan_pkg::ST_DONE;
          end
        end
      end
      flash_crc_scan_pkg::ST_FETCH:
      begin
        if (!enable)
        begin
          state_d = flash_crc_scan_pkg::ST_DONE;
        end
        else if (word_q == last_word)
        begin
          state_d = flash_crc_scan_pkg::ST_DRAIN;
        end
        else
        begin
          word_d = word_q + 16'h0001;
          rd_d = 1'b1;
        end
      end
      flash_crc_scan_pkg::ST_DRAIN:
      begin
        state_d = flash_crc_scan_pkg::ST_DONE;
      end
      flash_crc_scan_pkg::ST_DONE:
      begin
        state_d = flash_crc_scan_pkg::ST_IDLE;
      end
    endcase
  end

  // one word per clock; the final word folds in while draining
  assign res_d = res_wr ? sfr_req.wdata
              : (scanning && enable && data_valid_q) ? crc_next : res_q;

  assign rdata_d = !sfr_req.rd ? rdata_q
                : hit_ctrl ? {8'h00, ctrl_q & `CTRL_WMASK}
                : (hit_res && sfr_req.acc == flash_crc_scan_pkg::ACC_WORD) ? res_q
                : 16'h0000;

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= flash_crc_scan_pkg::ST_IDLE;
      word_q <= 16'h0000;
      rd_q <= 1'b0;
      data_valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      word_q <= word_d;
      rd_q <= rd_d;
      data_valid_q <= rd_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= `CTRL_RESET;
      res_q <= `RESULT_RESET;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      res_q <= res_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      release_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      release_q <= state_d == flash_crc_scan_pkg::ST_DONE;
      busy_q <= state_d == flash_crc_scan_pkg::ST_FETCH
             || state_d == flash_crc_scan_pkg::ST_DRAIN;
    end
  end

  assign sfr_rdata = rdata_q;
  assign halt_release = release_q;
  assign scan_busy = busy_q;
  assign flash_rd = rd_q;
  assign flash_addr = {word_q, 2'b00};
  assign flash_check_control = ctrl_q;
  assign flash_check_result = res_q;

endmodule

// [flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clock,
  input wire logic flash_rd,
  input wire logic [17:0] flash_addr,
  output logic [31:0] flash_rdata
);
  // word follows address; unread cycles toggle so stale data never looks fresh
  always @(posedge clock)
    flash_rdata <= flash_rd ? {~flash_addr[15:0], flash_addr[17:2]} : ~flash_rdata;
  initial flash_rdata = '0;
endmodule

// [flash_crc_scan_checker.sv]
`timescale 1ns/1ps
module flash_crc_scan_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic halt_exec,
  input wire logic halt_release,
  input wire logic scan_busy,
  input wire logic flash_rd,
  input wire logic [17:0] flash_addr,
  input wire logic [7:0] flash_check_control,
  input wire logic [15:0] flash_check_result
);
  logic [16:0] rd_n_q;
  wire logic en = flash_check_control[7];
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rd_n_q <= '0;
    else
      rd_n_q <= flash_rd ? rd_n_q + 17'h1 : '0;
  end
  chk_bit6_zero: assert property (!flash_check_control[6]) else $error("bit6");
  chk_halt_ignored: assert property (halt_exec && !en && !scan_busy |=>
    !scan_busy && !halt_release) else $error("halt");
  chk_rd_in_busy: assert property (flash_rd |-> scan_busy) else $error("rd");
  chk_start_zero: assert property ($rose(flash_rd) |->
    flash_addr == 18'h0) else $error("start");
  chk_addr_step: assert property (flash_rd && $past(flash_rd) |->
    flash_addr == $past(flash_addr) + 18'h4) else $error("step");
  chk_last_word: assert property ($fell(flash_rd) && en |->
    $past(flash_addr) == {flash_check_control[3:0], 14'h3ff8}) else $error("last");
  chk_scan_len: assert property ($fell(flash_rd) && en |->
    rd_n_q == {flash_check_control[4:0] + 5'h1, 12'h0} - 17'h1) else $error("len");
  chk_release_end: assert property ($fell(scan_busy) |-> halt_release)
    else $error("release");
  chk_result_held: assert property (!en && !scan_busy && !halt_release |=>
    $stable(flash_check_result)) else $error("result");
  cover property ($rose(scan_busy));
  cover property ($fell(scan_busy) && !en);
  cover property ($fell(flash_rd) && en);
  cover property (halt_release && !$past(scan_busy));
endmodule
bind flash_crc_scan flash_crc_scan_checker i_flash_crc_scan_checker (.clock, .resetn, .halt_exec,
  .halt_release, .scan_busy, .flash_rd, .flash_addr, .flash_check_control, .flash_check_result);

// [tb_flash_crc_scan.sv]
`timescale 1ns/1ps
module tb_flash_crc_scan;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic halt_exec = 1'b0;
  flash_crc_scan_pkg::sfr_req_s sfr_req = '0;
  logic [15:0] sfr_rdata, crc, flash_check_result;
  logic halt_release, scan_busy, flash_rd;
  logic [17:0] flash_addr;
  logic [31:0] flash_rdata, d;
  logic [7:0] flash_check_control;
  int fail_count = 0, cmp_count = 0, n;
  logic [19:0] ra [6] = '{20'hf02f0, 20'hf02f0, 20'hf02f2, 20'hf02f0, 20'hf02f2, 20'hf02f4};
  logic [1:0] rk [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h2};
  logic [15:0] rw [6] = '{16'hff, 16'h0, 16'h1234, 16'h80, 16'hbeef, 16'h5555};
  logic [15:0] re [6] = '{16'hbf, 16'h3f, 16'h0, 16'h80, 16'hbeef, 16'h0};
  always #4 clock = ~clock;
  flash_crc_scan i_flash_crc_scan (.clock, .resetn, .sfr_req, .sfr_rdata, .halt_exec,
    .halt_release, .scan_busy, .flash_rd, .flash_addr, .flash_rdata, .flash_check_control,
    .flash_check_result);
  flash_array_model i_flash_array_model (.clock, .flash_rd, .flash_addr, .flash_rdata);
  task xfer(input logic [19:0] a, input logic w, input logic [1:0] k, input logic [15:0] v);
    @(posedge clock);
    sfr_req <= '{a, w, !w, flash_crc_scan_pkg::acc_e'(k), v, 3'h7, v[0]};
    @(posedge clock);
    sfr_req <= '0;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // bounded wait: a missing release ends at cap instead of hanging
  task halt_run(input int cap, output int i);
    @(posedge clock);
    halt_exec <= 1'b1;
    @(posedge clock);
    halt_exec <= 1'b0;
    i = 1;
    @(negedge clock);
    while (halt_release !== 1'b1 && i < cap)
    begin
      @(negedge clock);
      i++;
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("control reset", 16'h0, {8'h0, flash_check_control});
    chk("result reset", 16'h0, flash_check_result);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      xfer(ra[i], 1'b1, rk[i], rw[i]);
      xfer(ra[i], 1'b0, ra[i][1] ? 2'h2 : 2'h1, 16'h0);
      @(negedge clock);
      chk("read back", re[i], sfr_rdata);
    end
    $display("test registers done");
    crc = 16'hbeef;
    for (int m = 0; m < 2; m++)
    begin
      xfer(20'hf02f0, 1'b1, 2'h1, 16'h80 + 16'(m));
      for (int a = 0; a < (m + 1) * 32'h4000 - 4; a += 4)
      begin
        d = {~a[15:0], a[17:2]};
        for (int b = 31; b >= 0; b--)
          crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[b]) ? 16'h1021 : 16'h0);
      end
      halt_run(70000, n);
      chk("scan cycles", 16'((m + 1) * 32'h1000 + 32'h1), n[15:0]);
      chk("checksum", crc, flash_check_result);
      chk("busy after", 16'h0, {15'h0, scan_busy});
      $display("test scan %0d done", m);
    end
    xfer(20'hf02f0, 1'b1, 2'h1, 16'h90);
    halt_run(20, n);
    chk("prohibited range", 16'h1, n[15:0]);
    chk("result kept", crc, flash_check_result);
    xfer(20'hf02f0, 1'b1, 2'h1, 16'h0);
    halt_run(20, n);
    chk("disabled halt", 16'h0, {15'h0, halt_release});
    // clearing enable by bit access ten cycles into a scan must abort it
    xfer(20'hf02f0, 1'b1, 2'h1, 16'h80);
    fork
      halt_run(40, n);
      begin
        repeat (10) @(posedge clock);
        xfer(20'hf02f0, 1'b1, 2'h0, 16'h0);
      end
    join
    chk("abort release", 16'hc, n[15:0]);
    chk("abort idle", 16'h0, {15'h0, scan_busy});
    $display("test refusals done");
    @(posedge clock);
    resetn <= 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("control mid reset", 16'h0, {8'h0, flash_check_control});
    chk("result mid reset", 16'h0, flash_check_result);
    chk("busy mid reset", 16'h0, {15'h0, scan_busy});
    $display("test mid reset done");
    end_of_test;
  end
endmodule
